// ### rtl/itx_pkg.sv
// Purpose: Constants and types for the serial transmit data path with its 16-byte FIFO.
// Assumes: AXI4-Lite register access with byte addresses; bit fields as listed below.
// Notes: Operation
package itx_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_RXD  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_TXD  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_FFTX = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_MODE = 4'hC;
  localparam int FFEN_BIT = 14;
  localparam int TXRST_BIT = 13;
  localparam int FILL_LSB = 8;
  localparam int FLAG_BIT = 7;
  localparam int CLR_BIT = 6;
  localparam int IENA_BIT = 5;
  localparam int THR_LSB = 0;
  localparam int BC_LSB = 0;
  localparam int FILL_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [4:0] THR_RST = 5'h00;
  localparam logic [2:0] BC_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [7:0] data;
    logic [3:0] nbits;
  } itx_shift_s;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } itx_shift_e;
endpackage

// ### rtl/itx_shifter.sv
// Purpose: Transmit shift register on the link clock, serialising one byte per request.
// Assumes: Request payload stays stable from a request toggle until the answering ack toggle.
// Notes: Most significant of the active bits goes first.
`timescale 1ns/1ps
module itx_shifter
  import itx_pkg::*;
(
  input  wire logic       link_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       req_tgl_in,
  input  wire itx_shift_s req_in,
  output logic            ack_tgl_out,
  output logic            sda_out,
  output logic            sda_oe_out
);
  logic       req_s1;
  logic       req_s2;
  logic       seen;
  itx_shift_e state;
  logic [7:0] sr;
  logic [3:0] left;
  logic       next_seen;
  itx_shift_e next_state;
  logic [7:0] next_sr;
  logic [3:0] next_left;
  logic       next_ack;
  logic       next_sda;
  logic       next_oe;

  always_comb
  begin
    next_seen  = seen;
    next_state = state;
    next_sr    = sr;
    next_left  = left;
    next_ack   = ack_tgl_out;
    next_sda   = 1'b1;
    next_oe    = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (req_s2 != seen)
        begin
          // Right-aligned byte moved up so its top active bit leads
          next_seen  = req_s2;
          next_sr    = req_in.data << (4'h8 - req_in.nbits);
          next_left  = req_in.nbits;
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        next_sda  = sr[7];
        next_oe   = 1'b1;
        next_sr   = {sr[6:0], 1'b0};
        next_left = left - 4'h1;
        if (left == 4'h1)
        begin
          next_state = ST_IDLE;
          next_ack   = ~ack_tgl_out;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      req_s1      <= 1'b0;
      req_s2      <= 1'b0;
      seen        <= 1'b0;
      state       <= ST_IDLE;
      sr          <= DATA_RST;
      left        <= 4'h0;
      ack_tgl_out <= 1'b0;
      sda_out     <= 1'b1;
      sda_oe_out  <= 1'b0;
    end
    else
    begin
      req_s1      <= req_tgl_in;
      req_s2      <= req_s1;
      seen        <= next_seen;
      state       <= next_state;
      sr          <= next_sr;
      left        <= next_left;
      ack_tgl_out <= next_ack;
      sda_out     <= next_sda;
      sda_oe_out  <= next_oe;
    end
  end

  chk_shift_len: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    (state == ST_IDLE && req_s2 != seen) |=> (state == ST_SHIFT && left == $past(req_in.nbits)))
    else $error("shift length not taken from bit count");
  cov_shift_done: cover property (@(posedge link_clk_in) disable iff (!rst_n_in)
    state == ST_SHIFT ##1 state == ST_IDLE);
endmodule

// ### rtl/itx_top.sv
// Purpose: Transmit data register, 16-byte transmit FIFO and control register behind AXI4-Lite.
// Assumes: Single-beat AXI4-Lite master; link clock runs while bytes are being shifted.
// Notes: Bytes cross to the link domain by a toggle handshake with a stable payload.
`timescale 1ns/1ps
module itx_top
  import itx_pkg::*;
#(
  parameter int DEPTH = itx_pkg::FIFO_DEPTH
)
(
  input  wire logic                      CLK_IN,
  input  wire logic                      RST_N_IN,
  input  wire logic                      LINK_CLK_IN,
  input  wire logic [itx_pkg::ADDR_W-1:0] AWADDR_IN,
  input  wire logic                      AWVALID_IN,
  output logic                           AWREADY_OUT,
  input  wire logic [31:0]               WDATA_IN,
  input  wire logic [3:0]                WSTRB_IN,
  input  wire logic                      WVALID_IN,
  output logic                           WREADY_OUT,
  output logic [1:0]                     BRESP_OUT,
  output logic                           BVALID_OUT,
  input  wire logic                      BREADY_IN,
  input  wire logic [itx_pkg::ADDR_W-1:0] ARADDR_IN,
  input  wire logic                      ARVALID_IN,
  output logic                           ARREADY_OUT,
  output logic [31:0]                    RDATA_OUT,
  output logic [1:0]                     RRESP_OUT,
  output logic                           RVALID_OUT,
  input  wire logic                      RREADY_IN,
  input  wire logic [7:0]                RX_DATA_IN,
  input  wire logic                      RX_LOAD_IN,
  output logic                           SDA_OUT_OUT,
  output logic                           SDA_OE_OUT,
  output logic                           TX_IRQ_OUT
);
  import itx_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam logic [FILL_W-1:0] FULL = FILL_W'(DEPTH);

  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] wa;
  logic [31:0]       wd;
  logic [3:0]        ws;
  logic              next_aw_held;
  logic              next_w_held;
  logic [ADDR_W-1:0] next_wa;
  logic [31:0]       next_wd;
  logic [3:0]        next_ws;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic [31:0]       rd_mux;
  logic              rd_map;
  logic              do_wr;

  logic [7:0]        mem [DEPTH];
  logic [7:0]        tx_data;
  logic [7:0]        rx_data;
  logic              ffen;
  logic              txrst;
  logic              flag;
  logic              iena;
  logic [4:0]        thr;
  logic [2:0]        bc;
  logic [PW-1:0]     wr_ptr;
  logic [PW-1:0]     rd_ptr;
  logic [FILL_W-1:0] fill;
  logic              hold_full;
  logic              req_tgl;
  itx_shift_s        payload;
  logic              ack_tgl;
  logic              ack_s1;
  logic              ack_s2;
  logic [7:0]        next_tx_data;
  logic [7:0]        next_rx_data;
  logic              next_ffen;
  logic              next_txrst;
  logic              next_flag;
  logic              next_iena;
  logic [4:0]        next_thr;
  logic [2:0]        next_bc;
  logic [PW-1:0]     next_wr_ptr;
  logic [PW-1:0]     next_rd_ptr;
  logic [FILL_W-1:0] next_fill;
  logic              next_hold_full;
  logic              next_req_tgl;
  itx_shift_s        next_payload;
  logic              next_irq;
  logic              busy;
  logic              pop;
  logic              take_hold;
  logic              push;
  logic              wr_txd;
  logic              wr_ctl_hi;
  logic              wr_ctl_lo;
  logic              clr_wr;
  logic              set_cond;
  logic [3:0]        nb;

  // Read decode; the shift register itself has no address
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_map = 1'b1;
    case (ARADDR_IN)
      OFF_RXD:  rd_mux[7:0] = rx_data;
      OFF_TXD:  rd_mux[7:0] = tx_data;
      OFF_FFTX: rd_mux[15:0] = {1'b0, ffen, txrst, fill, flag, 1'b0, iena, thr};
      OFF_MODE: rd_mux[2:0] = bc;
      default:  rd_map = 1'b0;
    endcase
  end

  assign do_wr = aw_held && w_held && !BVALID_OUT;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_wa      = wa;
    next_wd      = wd;
    next_ws      = ws;
    next_bvalid  = BVALID_OUT;
    next_bresp   = BRESP_OUT;
    next_rvalid  = RVALID_OUT;
    next_rdata   = RDATA_OUT;
    next_rresp   = RRESP_OUT;
    if (AWVALID_IN && AWREADY_OUT)
    begin
      next_aw_held = 1'b1;
      next_wa      = AWADDR_IN;
    end
    if (WVALID_IN && WREADY_OUT)
    begin
      next_w_held = 1'b1;
      next_wd     = WDATA_IN;
      next_ws     = WSTRB_IN;
    end
    if (BVALID_OUT && BREADY_IN)
      next_bvalid = 1'b0;
    if (do_wr)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wa == OFF_TXD || wa == OFF_FFTX || wa == OFF_MODE || wa == OFF_RXD) ? RESP_OKAY : RESP_DECERR;
    end
    if (RVALID_OUT && RREADY_IN)
      next_rvalid = 1'b0;
    if (ARVALID_IN && ARREADY_OUT)
    begin
      next_rvalid = 1'b1;
      next_rdata  = rd_mux;
      next_rresp  = rd_map ? RESP_OKAY : RESP_DECERR;
    end
    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      wa          <= '0;
      wd          <= 32'h0000_0000;
      ws          <= 4'h0;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT  <= 1'b0;
      BVALID_OUT  <= 1'b0;
      BRESP_OUT   <= RESP_OKAY;
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h0000_0000;
      RRESP_OUT   <= RESP_OKAY;
    end
    else
    begin
      aw_held     <= next_aw_held;
      w_held      <= next_w_held;
      wa          <= next_wa;
      wd          <= next_wd;
      ws          <= next_ws;
      AWREADY_OUT <= next_awready;
      WREADY_OUT  <= next_wready;
      BVALID_OUT  <= next_bvalid;
      BRESP_OUT   <= next_bresp;
      ARREADY_OUT <= next_arready;
      RVALID_OUT  <= next_rvalid;
      RDATA_OUT   <= next_rdata;
      RRESP_OUT   <= next_rresp;
    end
  end

  assign busy      = req_tgl != ack_s2;
  assign wr_txd    = do_wr && wa == OFF_TXD && ws[0];
  assign wr_ctl_hi = do_wr && wa == OFF_FFTX && ws[1];
  assign wr_ctl_lo = do_wr && wa == OFF_FFTX && ws[0];
  assign clr_wr    = wr_ctl_lo && wd[CLR_BIT];
  assign pop       = !busy && ffen && txrst && fill != '0;
  assign take_hold = !busy && !ffen && hold_full;
  assign push      = wr_txd && ffen && txrst && fill != FULL;
  assign set_cond  = ffen && txrst && fill <= thr;
  assign nb        = (bc == 3'h0) ? 4'h8 : {1'b0, bc};

  always_comb
  begin
    next_tx_data   = tx_data;
    next_rx_data   = rx_data;
    next_ffen      = ffen;
    next_txrst     = txrst;
    next_iena      = iena;
    next_thr       = thr;
    next_bc        = bc;
    next_wr_ptr    = wr_ptr;
    next_rd_ptr    = rd_ptr;
    next_fill      = fill;
    next_hold_full = hold_full;
    next_req_tgl   = req_tgl;
    next_payload   = payload;
    next_flag      = flag;
    if (RX_LOAD_IN)
      next_rx_data = RX_DATA_IN;
    if (pop)
    begin
      next_payload = '{data: mem[rd_ptr], nbits: nb};
      next_rd_ptr  = rd_ptr + PW'(1);
      next_req_tgl = ~req_tgl;
    end
    else if (take_hold)
    begin
      next_payload   = '{data: tx_data, nbits: nb};
      next_hold_full = 1'b0;
      next_req_tgl   = ~req_tgl;
    end
    if (push)
      next_wr_ptr = wr_ptr + PW'(1);
    case ({push, pop})
      2'b10:   next_fill = fill + FILL_W'(1);
      2'b01:   next_fill = fill - FILL_W'(1);
      default: next_fill = fill;
    endcase
    if (!txrst)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_fill   = '0;
    end
    if (wr_txd)
    begin
      next_tx_data = wd[7:0];
      if (!ffen)
        next_hold_full = 1'b1;
    end
    if (wr_ctl_hi)
    begin
      next_ffen  = wd[FFEN_BIT];
      next_txrst = wd[TXRST_BIT];
    end
    if (wr_ctl_lo)
    begin
      next_iena = wd[IENA_BIT];
      next_thr  = wd[THR_LSB +: 5];
    end
    if (do_wr && wa == OFF_MODE && ws[0])
      next_bc = wd[BC_LSB +: 3];
    // A set in the same cycle as a clear wins
    if (clr_wr)
      next_flag = 1'b0;
    if (set_cond)
      next_flag = 1'b1;
    next_irq = flag && iena;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (push)
      mem[wr_ptr] <= wd[7:0];
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      tx_data    <= DATA_RST;
      rx_data    <= DATA_RST;
      ffen       <= 1'b0;
      txrst      <= 1'b0;
      flag       <= 1'b0;
      iena       <= 1'b0;
      thr        <= THR_RST;
      bc         <= BC_RST;
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      fill       <= '0;
      hold_full  <= 1'b0;
      req_tgl    <= 1'b0;
      payload    <= '0;
      TX_IRQ_OUT <= 1'b0;
      ack_s1     <= 1'b0;
      ack_s2     <= 1'b0;
    end
    else
    begin
      tx_data    <= next_tx_data;
      rx_data    <= next_rx_data;
      ffen       <= next_ffen;
      txrst      <= next_txrst;
      flag       <= next_flag;
      iena       <= next_iena;
      thr        <= next_thr;
      bc         <= next_bc;
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      fill       <= next_fill;
      hold_full  <= next_hold_full;
      req_tgl    <= next_req_tgl;
      payload    <= next_payload;
      TX_IRQ_OUT <= next_irq;
      ack_s1     <= ack_tgl;
      ack_s2     <= ack_s1;
    end
  end

  itx_shifter u_shifter (
    .link_clk_in (LINK_CLK_IN),
    .rst_n_in    (RST_N_IN),
    .req_tgl_in  (req_tgl),
    .req_in      (payload),
    .ack_tgl_out (ack_tgl),
    .sda_out     (SDA_OUT_OUT),
    .sda_oe_out  (SDA_OE_OUT)
  );

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  chk_data_upper_zero: assert property ((ARVALID_IN && ARREADY_OUT && (ARADDR_IN == OFF_RXD || ARADDR_IN == OFF_TXD))
    |=> RVALID_OUT && RDATA_OUT[31:8] == 24'h000000)
    else $error("data register upper bits not zero");
  chk_ctl_reserved: assert property ((ARVALID_IN && ARREADY_OUT && ARADDR_IN == OFF_FFTX)
    |=> !RDATA_OUT[15] && !RDATA_OUT[CLR_BIT] && RDATA_OUT[12:8] == $past(fill))
    else $error("control register readback wrong");
  chk_hold_start: assert property ((hold_full && !ffen && !busy) |=> busy && payload.data == $past(tx_data))
    else $error("held byte not sent to shifter");
  chk_fifo_push: assert property ((push && !pop) |=> fill == $past(fill) + FILL_W'(1))
    else $error("push did not raise fill");
  chk_fifo_pop: assert property ((pop && !push && txrst) |=> fill == $past(fill) - FILL_W'(1) && busy)
    else $error("pop did not lower fill");
  chk_mode_off: assert property ((!ffen && txrst) |=> fill == $past(fill))
    else $error("FIFO moved while FIFO mode off");
  chk_fifo_hold: assert property (!txrst |=> fill == '0 && wr_ptr == '0 && rd_ptr == '0)
    else $error("FIFO not held in reset");
  chk_full_drop: assert property ((wr_txd && fill == FULL && !pop) |=> fill == FULL && wr_ptr == $past(wr_ptr))
    else $error("write to full FIFO not dropped");
  chk_flag_set: assert property (set_cond |=> flag)
    else $error("flag not set at threshold");
  chk_flag_sticky: assert property ((flag && !clr_wr) |=> flag)
    else $error("flag cleared without a clear write");
  chk_irq_out: assert property ((flag && iena) |=> TX_IRQ_OUT)
    else $error("interrupt not requested");
  chk_irq_gate: assert property (!(flag && iena) |=> !TX_IRQ_OUT)
    else $error("interrupt requested without flag and enable");
  chk_fill_range: assert property (fill <= FULL)
    else $error("fill above depth");

  cov_fifo_full: cover property (fill == FULL);
  cov_flag_clear: cover property (flag ##1 !flag);
  cov_hold_send: cover property (take_hold ##1 busy ##[1:200] !busy);
  cov_fifo_drain: cover property (pop && fill == FILL_W'(1));
endmodule

// ### tb/itx_bus_rx.sv
// Purpose: Receiving device on the serial data line; collects each shifted byte.
// Assumes: Line has a pull-up; sampled on the falling link edge, mid-bit.
// Notes: A byte ends when the output enable drops; entries are {bit count, byte}.
`timescale 1ns/1ps
module itx_bus_rx
(
  input  wire logic link_clk_in,
  input  wire logic sda_in,
  input  wire logic sda_oe_in
);
  logic [7:0]  shreg = 8'h00;
  logic [3:0]  nbits = 4'h0;
  logic [11:0] got_q[$];
  wire         line = sda_oe_in ? sda_in : 1'h1;

  always @(negedge link_clk_in)
  begin
    if (sda_oe_in)
    begin
      shreg = {shreg[6:0], line};
      nbits = nbits + 4'h1;
    end
    else if (nbits != 4'h0)
    begin
      got_q.push_back({nbits, shreg});
      shreg = 8'h00;
      nbits = 4'h0;
    end
  end
endmodule

// ### tb/itx_top_tb_top.sv
// Purpose: Self-checking bench for the transmit data register and FIFO.
// Assumes: Bus master holds each channel until its ready; receiver model on the line.
// Notes: Link clock is paused so the FIFO can fill while a byte is in flight.
`timescale 1ns/1ps
module itx_top_tb_top;
  import itx_pkg::*;
  logic        clk, lclk, rst_n, lrun;
  logic [3:0]  awaddr, araddr, wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready, rx_load;
  logic [31:0] wdata, rd, tmp;
  logic [7:0]  rx_data, b;
  logic [1:0]  rsp;
  wire         awready, wready, bvalid, arready, rvalid, sda, sda_oe, irq;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  int          err_count, cmp_count, n;
  int          cyc = 0;
  int unsigned seed;
  logic [11:0] exp_q[$];
  logic [7:0]  m_fifo[$];
  bit          m_busy;
  logic [3:0]  offs[4] = '{OFF_RXD, OFF_TXD, OFF_FFTX, OFF_MODE};

  itx_top DUT
  (
    .CLK_IN(clk), .RST_N_IN(rst_n), .LINK_CLK_IN(lclk),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .RX_DATA_IN(rx_data), .RX_LOAD_IN(rx_load),
    .SDA_OUT_OUT(sda), .SDA_OE_OUT(sda_oe), .TX_IRQ_OUT(irq)
  );

  itx_bus_rx PARTNER
  (
    .link_clk_in(lclk), .sda_in(sda), .sda_oe_in(sda_oe)
  );

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Unrelated phase; stands still while lrun is low
  initial
  begin
    lclk = 1'h0;
    #7;
    forever #24 if (lrun) lclk = ~lclk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      $display("Error timeout expected finish seen hang");
      wrap_up();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] ctl(input logic [31:0] base, input bit f);
    return base | (32'(m_fifo.size()) << FILL_LSB) | (32'(f) << FLAG_BIT);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (aw && w && bvalid)
        break;
      if (!aw && awready)
      begin
        aw = 1;
        awvalid <= 1'h0;
      end
      if (!w && wready)
      begin
        w = 1;
        wvalid <= 1'h0;
      end
    end
    rsp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rdt(input logic [3:0] a);
    bit ar;
    ar = 1;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (!ar && rvalid)
        break;
      if (ar && arready)
      begin
        ar = 0;
        arvalid <= 1'h0;
      end
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask

  task automatic wchk(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    chk("write resp", 32'(RESP_OKAY), 32'(rsp));
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    rdt(a);
    chk("read data", e, rd);
    chk("read resp", 32'(RESP_OKAY), 32'(rsp));
  endtask

  // First byte goes straight to the stalled shifter, the rest queue up until FIFO_DEPTH are held; later ones are dropped
  task automatic push();
    logic [31:0] v;
    v = rnd();
    wchk(OFF_TXD, v);
    if (!m_busy)
    begin
      m_busy = 1;
      exp_q.push_back({4'h8, v[7:0]});
    end
    else if (m_fifo.size() < FIFO_DEPTH)
      m_fifo.push_back(v[7:0]);
  endtask

  task automatic ser_chk();
    while (exp_q.size() > 0)
    begin
      while (PARTNER.got_q.size() == 0)
        @(posedge clk);
      chk("serial byte", 32'(exp_q.pop_front()), 32'(PARTNER.got_q.pop_front()));
    end
  endtask

  task automatic drain();
    lrun = 1;
    foreach (m_fifo[i])
      exp_q.push_back({4'h8, m_fifo[i]});
    m_fifo.delete();
    m_busy = 0;
    ser_chk();
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    seed = 19;
    err_count = 0;
    cmp_count = 0;
    lrun = 1;
    rst_n = 1'h0;
    {awaddr, araddr, wdata, rx_data} = '0;
    {awvalid, wvalid, bready, arvalid, rready, rx_load} = '0;
    wstrb = 4'hF;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    foreach (offs[i])
      rchk(offs[i], 32'h0);
    rdt(4'h2);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped resp", 32'(RESP_DECERR), 32'(rsp));
    wr(4'h2, 32'hFFFF_FFFF);
    chk("unmapped write", 32'(RESP_DECERR), 32'(rsp));
    $display("test registers done");
    tmp = rnd();
    @(posedge clk);
    rx_data <= tmp[7:0];
    rx_load <= 1'h1;
    @(posedge clk);
    rx_load <= 1'h0;
    wchk(OFF_RXD, 32'hFFFF_FFFF);
    rchk(OFF_RXD, {24'h0, tmp[7:0]});
    $display("test receive data done");
    for (int bc = 0; bc < 8; bc++)
    begin
      n = (bc == 0) ? 8 : bc;
      tmp = rnd();
      b = tmp[7:0] & 8'((1 << n) - 1);
      wchk(OFF_MODE, 32'(bc));
      wchk(OFF_TXD, {tmp[31:8], b});
      rchk(OFF_TXD, {24'h0, b});
      exp_q.push_back({4'(n), b});
      ser_chk();
    end
    wchk(OFF_MODE, 32'h0);
    $display("test bit counts done");
    wchk(OFF_FFTX, 32'h0000_BF25);
    rchk(OFF_FFTX, 32'h0000_2025);
    chk("irq", 32'h0, 32'(irq));
    lrun = 0;
    wchk(OFF_FFTX, 32'h0000_6024);
    rchk(OFF_FFTX, ctl(32'h6024, 1));
    chk("irq", 32'h1, 32'(irq));
    rchk(OFF_FFTX, ctl(32'h6024, 1));
    repeat (19) push();
    rchk(OFF_FFTX, ctl(32'h6024, 1));
    wchk(OFF_FFTX, 32'h0000_6064);
    rchk(OFF_FFTX, ctl(32'h6024, 0));
    chk("irq", 32'h0, 32'(irq));
    drain();
    rchk(OFF_FFTX, ctl(32'h6024, 1));
    chk("irq", 32'h1, 32'(irq));
    $display("test fifo fill done");
    lrun = 0;
    repeat (3) push();
    rchk(OFF_FFTX, ctl(32'h6024, 1));
    wchk(OFF_FFTX, 32'h0000_4024);
    m_fifo.delete();
    rchk(OFF_FFTX, 32'h0000_40A4);
    wchk(OFF_TXD, 32'h0000_005A);
    wchk(OFF_FFTX, 32'h0000_6024);
    rchk(OFF_FFTX, ctl(32'h6024, 1));
    drain();
    wchk(OFF_FFTX, 32'h0000_6004);
    rchk(OFF_FFTX, ctl(32'h6004, 1));
    chk("irq", 32'h0, 32'(irq));
    $display("test fifo reset done");
    wrap_up();
  end
endmodule
